// ==== verilog/hscp_pkg.sv ====
package hscp_pkg;
    // Address byte layout: bit 7 = read, bits 6:5 = data byte count
    localparam int ADDR_W = 8;
    localparam int READ_BIT = 7;
    localparam int CNT_HI = 6;
    localparam int CNT_LO = 5;
    localparam logic [1:0] CNT_MAX = 2'h2;
    localparam int SYNC_STAGES = 2;
    localparam logic [7:0] PSAVE_RESET = 8'hff;
    localparam logic [7:0] XTAL_AND_PORT_ON = 8'h03;

    typedef enum logic [1:0] {
        HSCP_ADDR = 2'b00,
        HSCP_DATA = 2'b01,
        HSCP_DONE = 2'b11
    } hscp_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] data;
        logic [1:0] count;
        logic read;
    } hscp_cmd_t;
endpackage

// ==== verilog/hscp_sync.sv ====
`timescale 1ns/1ps
module hscp_sync #(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // Data
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            meta_r <= '1;
            q_out <= '1;
        end else begin
            meta_r <= d_in;
            q_out <= meta_r;
        end
    end
endmodule

// ==== verilog/hscp_port.sv ====
// Contract
// R1: Host sends one to three bytes, MSB first; the port takes an address byte plus up to two data bytes
// R2: Reply bytes shifted out MSB first
// R3: Sample command_in on serial clock rise
// R4: Act on command when select rises
// R5: Work with either serial clock idle level
// R6: Drive reply after clock low, release on deselect
// R7: Reset leaves all but oscillator, port powersaved
// R8: First byte is address, sets direction, count
`timescale 1ns/1ps
module hscp_port (
    // Clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // Serial link pins
    input wire logic sclk_in,
    input wire logic chip_select_low_in,
    input wire logic command_in,
    output logic reply_out,
    output logic reply_oe_out,
    // Command to device core
    output hscp_pkg::hscp_cmd_t cmd_out,
    output logic cmd_valid_out,
    input wire logic [15:0] read_data_in,
    // Powersave state
    output logic [7:0] powersave_out
);
    logic [2:0] pins_s;
    logic sclk_s;
    logic csn_s;
    logic cdat_s;
    logic sclk_d_r;
    logic csn_d_r;
    logic rise;
    logic fall;
    logic sel_rise;
    logic sel_fall;
    hscp_pkg::hscp_state_t state_r;
    logic [2:0] bit_r;
    logic [7:0] shift_r;
    logic [7:0] addr_r;
    logic [15:0] data_r;
    logic [1:0] got_r;
    logic [15:0] tx_r;
    logic drive_r;
    logic [7:0] rx_byte;
    logic byte_done;
    logic frame_end;
    logic reply_shift;

    hscp_sync #(
        .WIDTH(3)
    ) u_sync (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .d_in({sclk_in, chip_select_low_in, command_in}),
        .q_out(pins_s)
    );

    assign sclk_s = pins_s[2];
    assign csn_s = pins_s[1];
    assign cdat_s = pins_s[0];

    function automatic logic [1:0] byte_count(input logic [7:0] a);
        byte_count = (a[hscp_pkg::CNT_HI:hscp_pkg::CNT_LO] > hscp_pkg::CNT_MAX)
            ? hscp_pkg::CNT_MAX : a[hscp_pkg::CNT_HI:hscp_pkg::CNT_LO];
    endfunction

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sclk_d_r <= 1'b0;
        end else begin
            sclk_d_r <= sclk_s;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            csn_d_r <= 1'b1;
        end else begin
            csn_d_r <= csn_s;
        end
    end

    // Edges count only while selected, so idle level of the clock is irrelevant
    assign rise = !csn_s && sclk_s && !sclk_d_r && !csn_d_r; // R3 R5
    assign fall = !csn_s && !sclk_s && sclk_d_r; // R5
    assign sel_fall = csn_d_r && !csn_s;
    assign sel_rise = !csn_d_r && csn_s;
    assign rx_byte = {shift_r[6:0], cdat_s}; // R1
    assign byte_done = rise && (bit_r == 3'h7);
    assign frame_end = sel_rise && (state_r == hscp_pkg::HSCP_DONE); // R4
    assign reply_shift = fall && (state_r != hscp_pkg::HSCP_ADDR);

    // Bit position within the current byte
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            bit_r <= 3'h0;
        end else if (sel_fall) begin
            bit_r <= 3'h0;
        end else if (rise) begin
            bit_r <= bit_r + 3'h1;
        end
    end

    // Serial input shifter, first bit ends up in bit 7
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            shift_r <= 8'h00;
        end else if (rise) begin
            shift_r <= rx_byte; // R1 R3
        end
    end

    // Address byte capture
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            addr_r <= 8'h00;
        end else if (byte_done && state_r == hscp_pkg::HSCP_ADDR) begin
            addr_r <= rx_byte; // R8
        end
    end

    // Data bytes, first of two lands in the upper half, a single byte in the lower
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            data_r <= 16'h0000;
            got_r <= 2'h0;
        end else if (sel_fall) begin
            data_r <= 16'h0000;
            got_r <= 2'h0;
        end else if (byte_done && state_r == hscp_pkg::HSCP_DATA) begin
            data_r <= {data_r[7:0], rx_byte}; // R1
            got_r <= got_r + 2'h1;
        end
    end

    // Receive state machine: address byte, then its data bytes
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_r <= hscp_pkg::HSCP_ADDR;
        end else if (sel_fall) begin
            state_r <= hscp_pkg::HSCP_ADDR;
        end else if (byte_done) begin
            case (state_r)
                hscp_pkg::HSCP_ADDR: begin
                    state_r <= (byte_count(rx_byte) == 2'h0)
                        ? hscp_pkg::HSCP_DONE : hscp_pkg::HSCP_DATA; // R8
                end
                hscp_pkg::HSCP_DATA: begin
                    if (got_r + 2'h1 == byte_count(addr_r)) begin
                        state_r <= hscp_pkg::HSCP_DONE;
                    end
                end
                default: begin
                    state_r <= hscp_pkg::HSCP_DONE;
                end
            endcase
        end
    end

    // Command strobe, raised only on deselect after a complete frame
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cmd_valid_out <= 1'b0;
        end else begin
            cmd_valid_out <= frame_end; // R4
        end
    end

    // Command payload holds until the next complete frame
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cmd_out <= '0;
        end else if (frame_end) begin
            cmd_out.addr <= addr_r; // R4
            cmd_out.data <= data_r;
            cmd_out.count <= byte_count(addr_r);
            cmd_out.read <= addr_r[hscp_pkg::READ_BIT];
        end
    end

    // Reply word loads when the address byte completes
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tx_r <= 16'h0000;
        end else if (byte_done && state_r == hscp_pkg::HSCP_ADDR) begin
            tx_r <= (byte_count(rx_byte) == 2'h1)
                ? {read_data_in[7:0], 8'h00} : read_data_in;
        end else if (reply_shift) begin
            tx_r <= {tx_r[14:0], 1'b0}; // R2
        end
    end

    // Reply bit changes on falling serial clock edges only
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            reply_out <= 1'b0;
        end else if (reply_shift) begin
            reply_out <= tx_r[15]; // R2
        end
    end

    // Output enable follows a low clock phase, drops on deselect
    // A new frame starts released, so a stale read address cannot drive early
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            drive_r <= 1'b0;
        end else if (csn_s || sel_fall) begin
            drive_r <= 1'b0; // R6
        end else if (!sclk_s && addr_r[hscp_pkg::READ_BIT]
                     && state_r != hscp_pkg::HSCP_ADDR) begin
            drive_r <= 1'b1; // R6
        end
    end

    assign reply_oe_out = drive_r && !csn_s; // R6

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            powersave_out <= hscp_pkg::PSAVE_RESET & ~hscp_pkg::XTAL_AND_PORT_ON; // R7
        end else if (cmd_valid_out && !cmd_out.read && cmd_out.count != 2'h0) begin
            powersave_out <= cmd_out.data[7:0] & ~hscp_pkg::XTAL_AND_PORT_ON; // R7
        end
    end
endmodule

// ==== sim/hscp_host.sv ====
`timescale 1ns/1ps
module hscp_host (
    // Serial link
    output logic sclk_out,
    output logic csn_out,
    output logic cmd_out,
    input wire logic reply_in
);
    initial begin
        sclk_out = 0;
        csn_out = 1;
        cmd_out = 0;
    end
    task automatic frame(input logic [23:0] b, input int n, input logic idle,
                         output logic [15:0] got);
        got = 16'h0000;
        sclk_out = idle;
        #10 csn_out = 0;
        #40;
        for (int i = n - 1; i >= 0; i--) begin
            sclk_out = 0;
            cmd_out = b[i];
            #24 sclk_out = 1;
            got = {got[14:0], reply_in};
            #24;
        end
        sclk_out = idle;
        #40 csn_out = 1;
        // Released line shows no stale value
        cmd_out = ~cmd_out;
        #60;
    endtask
endmodule

// ==== sim/hscp_port_props.sv ====
`timescale 1ns/1ps
module hscp_port_props (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic sclk_in,
    input wire logic chip_select_low_in,
    input wire logic reply_out,
    input wire logic reply_oe_out,
    input wire hscp_pkg::hscp_cmd_t cmd_out,
    input wire logic cmd_valid_out,
    input wire logic [7:0] powersave_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    sequence s_desel;
        chip_select_low_in [*4];
    endsequence
    a_oe_off_idle: assert property (s_desel |-> !reply_oe_out) else $error("oe while idle");
    a_oe_release: assert property ($rose(chip_select_low_in) |-> ##[0:4] !reply_oe_out)
        else $error("oe held");
    a_oe_after_low: assert property ($rose(reply_oe_out) |-> !$past(sclk_in, 3))
        else $error("oe not after low");
    a_reply_on_fall: assert property (reply_oe_out && $past(reply_oe_out) && $changed(reply_out)
        |-> !$past(sclk_in, 3)) else $error("reply moved");
    a_valid_at_end: assert property (cmd_valid_out |-> $past(chip_select_low_in, 3))
        else $error("early command");
    a_valid_pulse: assert property (cmd_valid_out |=> !cmd_valid_out) else $error("long pulse");
    a_cmd_holds: assert property (!cmd_valid_out |-> $stable(cmd_out)) else $error("cmd moved");
    a_psave_cmd: assert property ($changed(powersave_out) |-> $past(cmd_valid_out) || cmd_valid_out)
        else $error("powersave moved");
endmodule
bind hscp_port hscp_port_props u_props (.*);

// ==== sim/host_serial_command_port_test.sv ====
`timescale 1ns/1ps
module host_serial_command_port_test;
    logic clk_in = 0;
    logic nrst_in = 0;
    logic sclk, chip_select_low, cmd, reply, oe, valid;
    hscp_pkg::hscp_cmd_t cmd_o, last;
    logic [15:0] rdata = 16'h0000;
    logic [15:0] got;
    logic [7:0] ps;
    int n_fail = 0, n_compared = 0, n_valid = 0, cyc = 0, n_oe = 0;
    // Undriven reply line shows the inverse of the last bit, never a stale copy
    wire line = oe ? reply : ~reply;
    always #2.5 clk_in = ~clk_in;
    hscp_port u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .sclk_in(sclk),
        .chip_select_low_in(chip_select_low), .command_in(cmd), .reply_out(reply), .reply_oe_out(oe),
        .cmd_out(cmd_o), .cmd_valid_out(valid), .read_data_in(rdata), .powersave_out(ps));
    hscp_host u_host (.sclk_out(sclk), .csn_out(chip_select_low), .cmd_out(cmd), .reply_in(line));
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (oe === 1'b1) begin
            n_oe <= n_oe + 1;
        end
        if (valid === 1'b1) begin
            n_valid <= n_valid + 1;
            last <= cmd_o;
        end
        if (cyc == 20000) begin
            n_fail++;
            test_done();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic frame(input logic [23:0] b, input int n, input logic idle);
        u_host.frame(b, n, idle, got);
        repeat (8) @(negedge clk_in);
    endtask
    task automatic t_write;
        frame(24'h00205a, 16, 1'b0);
        check(last.addr, 8'h20);
        check(last.data[7:0], 8'h5a);
        check({last.read, last.count}, 3'h1);
        check(ps, 8'h58);
        check(n_oe, 0);
    endtask
    task automatic t_idle_high;
        frame(24'h401234, 24, 1'b1);
        check(last.data, 16'h1234);
        check(n_valid, 2);
    endtask
    task automatic t_read;
        rdata = 16'hb3c5;
        frame(24'hc00000, 24, 1'b0);
        check(got, 16'hb3c5);
        check({last.read, last.count}, 3'h6);
        check(oe, 1'b0);
        check(n_oe != 0, 1'b1);
    endtask
    task automatic t_short;
        int k;
        k = n_oe;
        frame(24'h00000a, 4, 1'b0);
        check(n_valid, 3);
        check(n_oe, k);
    endtask
    task test_done;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge clk_in);
        nrst_in = 1;
        repeat (4) @(negedge clk_in);
        check(ps, 8'hfc);
        t_write();
        t_idle_high();
        t_read();
        t_short();
        test_done();
    end
endmodule
